// [dv/ssp_master.sv]
`timescale 1ns/1ps
module ssp_master (
  // burst request
  input wire logic go,
  input wire logic [4:0] n,
  // link clock
  output logic sclk
);
  initial sclk = 1'b1;
  always @(posedge go) begin
    #3;
    repeat (n) begin
      sclk = 1'b0;
      #16;
      sclk = 1'b1;
      #16;
    end
  end
endmodule : ssp_master

// [dv/ssp_slave_asserts.sv]
`timescale 1ns/1ps
module ssp_slave_asserts #(
  parameter int unsigned HOLD_CYC = 50
) (
  // watched ports
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [18:0] RESOLUTION,
  input wire logic FAULT,
  input wire logic [4:0] WORD_WIDTH,
  input wire logic BUSY,
  input wire logic SSI_CLOCK,
  input wire logic SSI_DATA
);
  logic [15:0] q_reg;
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  always_ff @(posedge SYS_CLK) begin
    q_reg <= (RST || $changed(SSI_CLOCK)) ? 16'h0 : q_reg + 16'h1;
  end
  rst_idle_a: assert property (disable iff (1'b0) RST |=> SSI_DATA && !BUSY) else $error("rst");
  idle_high_a: assert property (!BUSY |-> SSI_DATA) else $error("idle");
  start_a: assert property ($fell(SSI_CLOCK) && !BUSY |-> ##[1:6] BUSY) else $error("start");
  frozen_a: assert property ($rose(BUSY) |-> SSI_DATA) else $error("frozen");
  retrig_a: assert property (BUSY && $changed(SSI_CLOCK) |=> BUSY [*8]) else $error("retrig");
  hold_len_a: assert property ($fell(BUSY) |-> q_reg >= HOLD_CYC && q_reg <= HOLD_CYC + 6) else $error("hold");
  hold_low_a: assert property ($fell(BUSY) |-> SSI_DATA && !$past(SSI_DATA)) else $error("low");
  width_a: assert property ((RESOLUTION == 19'h40000) [*3] |-> WORD_WIDTH == 5'h12) else $error("width");
  cover property ($rose(BUSY));
  cover property ($fell(BUSY));
  cover property (FAULT && BUSY);
endmodule : ssp_slave_asserts
bind ssp_slave ssp_slave_asserts #(.HOLD_CYC(HOLD_CYC)) u_chk (.SYS_CLK, .RST, .RESOLUTION, .FAULT,
  .WORD_WIDTH, .BUSY, .SSI_CLOCK, .SSI_DATA);

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pv = 1'b0;
  logic flt = 1'b0;
  logic go = 1'b0;
  logic [4:0] n = 5'h0;
  logic [17:0] pos = 18'h0;
  logic [18:0] res = 19'h40000;
  logic sclk;
  logic busy;
  logic sd;
  logic [4:0] ww;
  logic rdy;
  logic q[$];
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed = 32'h8665b84f;
  logic [18:0] tr[8] = '{19'h4, 19'h5, 19'h400, 19'h401, 19'h40000, 19'h40000, 19'h1, 19'h7ffff};
  logic [4:0] tw[8] = '{5'h2, 5'h3, 5'ha, 5'hb, 5'h12, 5'h12, 5'h2, 5'h12};
  ssp_slave #(.HOLD_CYC(50)) dut (.SYS_CLK(clk), .RST(rst), .POS_DATA(pos), .POS_VALID(pv), .POS_READY(rdy),
    .RESOLUTION(res), .FAULT(flt), .WORD_WIDTH(ww), .BUSY(busy), .SSI_CLOCK(sclk), .SSI_DATA(sd));
  ssp_master u_mst (.go(go), .n(n), .sclk(sclk));
  always #2 clk = ~clk;
  task automatic stop_test();
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic check(string nm, logic [17:0] s, logic [17:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask : check
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      stop_test();
    end
  end
  // one bit per rising link edge, then hold low
  always @(posedge sclk) if (q.size() > 0) begin
    #24;
    check("bit", sd, q.pop_front());
  end
  task automatic xfer(logic [4:0] w, logic [17:0] v);
    for (int i = w - 1; i >= 0; i--) q.push_back(flt | v[i]);
    q.push_back(1'b0);
    n <= w + 5'h1;
    go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    repeat (w * 8 + 78) @(posedge clk);
    check("idle", {busy, sd}, 2'b01);
    check("ready", rdy, 1'b1);
  endtask : xfer
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    check("width", ww, 5'h12);
    foreach (tw[i]) begin
      res <= tr[i];
      flt <= (i == 5);
      repeat (20) begin
        pos <= 18'($random(seed));
        pv <= 1'b1;
        @(posedge clk);
      end
      pv <= 1'b0;
      repeat (8) @(posedge clk);
      check("width", ww, tw[i]);
      xfer(tw[i], pos);
    end
    stop_test();
  end
endmodule : tb_top

// [logic/ssp_fifo.sv]
`timescale 1ns/1ps
module ssp_fifo #(
  parameter int unsigned W = 19,
  parameter int unsigned D = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write side
  input wire logic [W-1:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  // read side
  output logic [W-1:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic do_wr;
  logic do_rd;

  assign wr_ready = (cnt_reg != D[AW:0]);
  assign rd_valid = (cnt_reg != '0);
  assign do_wr = wr_valid && wr_ready;
  assign do_rd = rd_valid && rd_ready;
  assign rd_data = mem[rp_reg];

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wp_reg] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_wr) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (do_rd) begin
        rp_reg <= rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end
  end
endmodule : ssp_fifo

// [logic/ssp_pkg.sv]
package ssp_pkg;
  // ----------------------------------------
  // widths and defaults
  // ----------------------------------------
  localparam int unsigned POS_W = 18;
  localparam logic [4:0] WIDTH_MIN = 5'h02;
  localparam logic [18:0] RES_MAX = 19'h40000;
  localparam logic [18:0] RES_MIN = 19'h00004;
  localparam logic [18:0] RES_DEFAULT = 19'h40000;
  localparam int unsigned FIFO_W = 19;
  localparam int unsigned FIFO_D = 16;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned HOLD_TIMEOUT_US = 25;
  localparam int unsigned HOLD_TIMEOUT_CYC = HOLD_TIMEOUT_US * CLK_MHZ;
endpackage : ssp_pkg

// [logic/ssp_slave.sv]
// Functional notes
// - between transfers the shift register keeps reloading the present position
// - first falling clock edge starts hold timeout and freezes the register
// - each later rising edge drives next bit, most significant first
// - every clock edge restarts the timeout; no reload while it runs
// - after the burst data stays low until timeout ends, then reload
// - resolution configurable 4 to 262144, default 262144
// - on internal fault every shifted bit is one
`timescale 1ns/1ps
module ssp_slave #(
  parameter int unsigned HOLD_CYC = ssp_pkg::HOLD_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // position source
  input wire logic [ssp_pkg::POS_W-1:0] POS_DATA,
  input wire logic POS_VALID,
  output logic POS_READY,
  // configuration and status
  input wire logic [18:0] RESOLUTION,
  input wire logic FAULT,
  output logic [4:0] WORD_WIDTH,
  output logic BUSY,
  // link pins
  input wire logic SSI_CLOCK,
  output logic SSI_DATA
);
  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_SHIFT = 3'b010,
    ST_HOLD = 3'b100
  } ssp_state_t;

  // ----------------------------------------
  // configuration
  // ----------------------------------------
  logic [18:0] res_eff;
  logic [18:0] res_m1;
  logic [4:0] width_c;
  always_comb begin
    res_eff = RESOLUTION;
    if (RESOLUTION < ssp_pkg::RES_MIN) begin
      res_eff = ssp_pkg::RES_MIN;
    end else if (RESOLUTION > ssp_pkg::RES_MAX) begin
      res_eff = ssp_pkg::RES_MAX;
    end
    res_m1 = res_eff - 19'h00001;
    width_c = ssp_pkg::WIDTH_MIN;
    for (int i = 0; i < 19; i++) begin
      if (res_m1[i]) begin
        width_c = 5'(i + 1);
      end
    end
  end

  logic [4:0] width_reg;
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      width_reg <= 5'(ssp_pkg::POS_W);
    end else begin
      width_reg <= width_c;
    end
  end
  assign WORD_WIDTH = width_reg;

  // ----------------------------------------
  // position buffer
  // ----------------------------------------
  logic [ssp_pkg::FIFO_W-1:0] fifo_rd_data;
  logic fifo_rd_valid;
  logic fifo_rd_ready;
  ssp_fifo #(
    .W(ssp_pkg::FIFO_W),
    .D(ssp_pkg::FIFO_D)
  ) u_fifo (
    .clk(SYS_CLK),
    .rst(RST),
    .wr_data({1'b0, POS_DATA}),
    .wr_valid(POS_VALID),
    .wr_ready(POS_READY),
    .rd_data(fifo_rd_data),
    .rd_valid(fifo_rd_valid),
    .rd_ready(fifo_rd_ready)
  );

  // ----------------------------------------
  // link clock sampling
  // ----------------------------------------
  logic [2:0] clk_sync_reg;
  logic clk_lvl_reg;
  logic fall_evt;
  logic rise_evt;
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      clk_sync_reg <= 3'h7;
      clk_lvl_reg <= 1'b1;
    end else begin
      clk_sync_reg <= {clk_sync_reg[1:0], SSI_CLOCK};
      if (clk_sync_reg[2] == clk_sync_reg[1]) begin
        clk_lvl_reg <= clk_sync_reg[1];
      end
    end
  end
  assign fall_evt = clk_lvl_reg && (clk_sync_reg[2] == clk_sync_reg[1]) && !clk_sync_reg[1];
  assign rise_evt = !clk_lvl_reg && (clk_sync_reg[2] == clk_sync_reg[1]) && clk_sync_reg[1];

  // ----------------------------------------
  // transfer control
  // ----------------------------------------
  ssp_state_t state_reg;
  logic [31:0] tmo_reg;
  logic [17:0] shift_reg;
  logic [4:0] left_reg;
  logic data_reg;
  logic fault_reg;
  logic [17:0] pos_reg;

  assign fifo_rd_ready = 1'b1;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      fault_reg <= 1'b0;
      pos_reg <= '0;
    end else begin
      fault_reg <= FAULT;
      if (fifo_rd_valid) begin
        pos_reg <= fifo_rd_data[17:0];
      end
    end
  end

  logic clk_evt;
  logic tmo_done;
  assign clk_evt = fall_evt || rise_evt;
  assign tmo_done = (tmo_reg == 32'h0);

  // ----------------------------------------
  // transfer state
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_reg <= ST_LOAD;
    end else begin
      case (state_reg)
        ST_LOAD: begin
          if (fall_evt) begin
            state_reg <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (rise_evt && left_reg == 5'h00) begin
            state_reg <= ST_HOLD;
          end else if (!clk_evt && tmo_done) begin
            state_reg <= ST_LOAD;
          end
        end
        ST_HOLD: begin
          if (!clk_evt && tmo_done) begin
            state_reg <= ST_LOAD;
          end
        end
        default: begin
          state_reg <= ST_LOAD;
        end
      endcase
    end
  end

  // ----------------------------------------
  // hold timeout
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      tmo_reg <= '0;
    end else if (state_reg == ST_LOAD) begin
      if (fall_evt) begin
        tmo_reg <= HOLD_CYC;
      end
    end else if (clk_evt) begin
      tmo_reg <= HOLD_CYC;
    end else if (!tmo_done) begin
      tmo_reg <= tmo_reg - 32'h1;
    end
  end

  // ----------------------------------------
  // shift register
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      shift_reg <= '0;
      left_reg <= '0;
    end else if (state_reg == ST_LOAD) begin
      shift_reg <= fault_reg ? '1 : (pos_reg << (5'(ssp_pkg::POS_W) - width_reg));
      left_reg <= width_reg;
    end else if (state_reg == ST_SHIFT && rise_evt && left_reg != 5'h00) begin
      shift_reg <= {shift_reg[16:0], 1'b0};
      left_reg <= left_reg - 5'h01;
    end
  end

  // ----------------------------------------
  // data line
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      data_reg <= 1'b1;
    end else begin
      case (state_reg)
        ST_LOAD: begin
          data_reg <= 1'b1;
        end
        ST_SHIFT: begin
          if (rise_evt && left_reg != 5'h00) begin
            data_reg <= shift_reg[17] | fault_reg;
          end else if (rise_evt) begin
            data_reg <= 1'b0;
          end else if (!clk_evt && tmo_done) begin
            data_reg <= 1'b1;
          end
        end
        ST_HOLD: begin
          if (!clk_evt && tmo_done) begin
            data_reg <= 1'b1;
          end else begin
            data_reg <= 1'b0;
          end
        end
        default: begin
          data_reg <= 1'b1;
        end
      endcase
    end
  end

  assign SSI_DATA = data_reg;
  assign BUSY = (state_reg != ST_LOAD);
endmodule : ssp_slave
